// file: pctsc_pkg.sv
// Shared constants for the trigger decoder, frame builder and slow-channel sequencer.
package pctsc_pkg;
	// Clock and unit tick time.
	localparam int CLK_MHZ      = 40;
	localparam int UNIT_TICK_NS = 3000;
	localparam int UT_CYC       = (UNIT_TICK_NS * CLK_MHZ) / 1000 < 1 ? 1 : (UNIT_TICK_NS * CLK_MHZ) / 1000;

	// Trigger low-time decoding, in unit ticks.
	localparam logic [7:0] TRIG_MIN_TICKS   = 8'h01;
	localparam logic [7:0] CONST_BASE_TICKS = 8'h03;
	localparam logic [7:0] VAR_BASE_TICKS   = 8'h06;
	localparam logic [7:0] ID_STEP_TICKS    = 8'h03;
	localparam logic [7:0] ID_TOL_TICKS     = 8'h01;

	// Protocol setup word fields.
	localparam int SETUP_INTERLEAVE = 0;
	localparam int SETUP_BLK_LO     = 1;
	localparam int SETUP_BLK_HI     = 3;
	localparam int SETUP_SLOW_OFF   = 4;
	localparam int SETUP_VARLEN     = 9;
	localparam int SETUP_BUS_MODE   = 10;
	localparam logic [2:0] BLK5_COUNT = 3'h4;

	// Slow-channel message identities and framing.
	localparam logic [7:0] MSG_ID_ERROR = 8'h01;
	localparam logic [7:0] MSG_ID_OEM5  = 8'h94;
	localparam logic [4:0] SLOW_FRAMES  = 5'h12;
	localparam logic [5:0] CRC6_SEED    = 6'h15;
	localparam logic [5:0] CRC6_POLY    = 6'h19;
	localparam logic [3:0] CRC4_SEED    = 4'h5;
	localparam logic [3:0] CRC4_POLY    = 4'hd;

	// Error flag positions and fast-channel error values.
	localparam logic [10:0] FATAL_MASK   = 11'h217;
	localparam logic [10:0] WARN_MASK    = 11'h4c8;
	localparam logic [10:0] FLAG_VALID   = 11'h6ff;
	localparam int          FLAG_CLAMP   = 5;
	localparam logic [11:0] FAST_FATAL   = 12'hffa;
	localparam logic [11:0] FAST_WARN    = 12'hffb;

	// Self-check status word masks.
	localparam logic [15:0] STAT_A_MASK  = 16'hfefe;
	localparam logic [15:0] STAT_B_MASK  = 16'h5f00;
	localparam logic [15:0] STAT_B_RESET = 16'h00ff;

	// Items handed to the nibble encoder.
	typedef enum logic [1:0] {PCTSC_SYNC, PCTSC_NIB, PCTSC_END} pctsc_kind_t;
endpackage : pctsc_pkg

// file: pctsc_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module pctsc_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	// Asynchronous input and synchronised output.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pctsc_sync

// file: pctsc_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module pctsc_buf2 #(
	parameter int W = 6
) (
	// Clock and reset.
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	// Filling side.
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side.
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem_q [2];
	logic         wr_q;
	logic         rd_q;
	logic [1:0]   cnt_q;
	wire          push = in_valid && in_ready;
	wire          pop  = out_valid && out_ready;

	// Honest full and empty come straight from the fill count.
	assign in_ready  = cnt_q != 2'h2;
	assign out_valid = cnt_q != 2'h0;
	assign out_data  = mem_q[rd_q];

	// Storage is only written, so it needs no reset.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and count.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			wr_q  <= wr_q ^ push;
			rd_q  <= rd_q ^ pop;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : pctsc_buf2

// file: pctsc_core.sv
// Triggered nibble-frame builder with slow channel, error mapping and self-check words.
`timescale 1ns/1ps
module pctsc_core #(
	parameter int UT_CYCLES = pctsc_pkg::UT_CYC
) (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Shared open-drain line.
	input  wire logic        line_in,
	output logic             line_out,
	output logic             line_oe,
	// Sensor ID straps.
	input  wire logic        strap_id_a,
	input  wire logic        strap_id_b,
	// Configuration.
	input  wire logic [15:0] protocol_setup,
	input  wire logic [15:0] user_config_word_7,
	input  wire logic [15:0] user_config_word_8,
	input  wire logic [15:0] user_config_word_9,
	input  wire logic [11:0] clamp_low,
	input  wire logic [11:0] clamp_high,
	// Measurement and diagnostics.
	input  wire logic [11:0] meas_value,
	input  wire logic [10:0] err_flags,
	input  wire logic        path_underflow,
	input  wire logic        path_overflow,
	input  wire logic [15:0] self_check_a_in,
	input  wire logic [15:0] self_check_b_in,
	// Nibble encoder side.
	output logic             nib_valid,
	input  wire logic        nib_ready,
	output logic [1:0]       nib_kind,
	output logic [3:0]       nib_data,
	input  wire logic        enc_pull_low,
	input  wire logic        enc_frame_done,
	// Status.
	output logic [15:0]      self_check_status_a,
	output logic [15:0]      self_check_status_b,
	output logic             device_reset_req,
	output logic             frame_active,
	output logic [1:0]       sensor_id
);
	typedef enum logic [2:0] {S_IDLE, S_SYNC, S_STAT, S_DATA, S_CRC, S_END, S_WAIT} pctsc_state_t;

	// One CRC-4 step over a nibble.
	function automatic logic [3:0] crc4_step(input logic [3:0] c, input logic [3:0] d);
		logic [3:0] r;
		logic       fb;
		r = c;
		for (int i = 3; i >= 0; i--) begin
			fb = r[3] ^ d[i];
			r  = {r[2:0], 1'b0} ^ (fb ? pctsc_pkg::CRC4_POLY : 4'h0);
		end
		return r;
	endfunction : crc4_step

	// Serial start and ID bit carried in the upper slow bit of frame k.
	function automatic logic slow_hi_bit(input logic [4:0] k, input logic [7:0] id);
		logic b;
		b = 1'b0;
		if (k < 5'h06) begin
			b = 1'b1;
		end else if (k >= 5'h08 && k <= 5'h0b) begin
			b = id[3'(5'h0f - k)];
		end else if (k >= 5'h0d && k <= 5'h10) begin
			b = id[3'(5'h10 - k)];
		end
		return b;
	endfunction : slow_hi_bit

	// CRC-6 over the twelve ID/data bit pairs, augmented by six zero pairs.
	function automatic logic [5:0] crc6(input logic [7:0] id, input logic [11:0] d);
		logic [5:0] c;
		logic [2:0] bits;
		logic       fb;
		c = pctsc_pkg::CRC6_SEED;
		for (int k = 6; k < 24; k++) begin
			bits = (k < 18) ? {slow_hi_bit(5'(k), id), d[4'(17 - k)], 1'b1} : 3'h0;
			for (int j = 2; j >= 1; j--) begin
				fb = c[5] ^ (bits[j] & bits[0]);
				c  = {c[4:0], 1'b0} ^ (fb ? pctsc_pkg::CRC6_POLY : 6'h00);
			end
		end
		return c;
	endfunction : crc6

	// True when a measured low time falls in the window of the given ID.
	function automatic logic id_window(input logic [7:0] t, input logic [7:0] base, input logic [1:0] id);
		logic [7:0] nom;
		nom = base + 8'(id) * pctsc_pkg::ID_STEP_TICKS;
		return (t + pctsc_pkg::ID_TOL_TICKS >= nom) && (t <= nom + pctsc_pkg::ID_TOL_TICKS);
	endfunction : id_window

	// Pin synchronisation.
	logic [2:0] pins_s;
	pctsc_sync #(.W(3)) u_sync (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.async_in ({line_in, strap_id_b, strap_id_a}),
		.sync_out (pins_s)
	);
	wire line_s = pins_s[2];

	// Straps are caught on the first three cycles after reset and then held; the last catch is the cycle after the synchroniser has filled.
	logic [1:0] strap_q;
	logic [1:0] cap_cnt_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			strap_q   <= 2'h0;
			cap_cnt_q <= 2'h0;
		end else if (cap_cnt_q != 2'h3) begin
			cap_cnt_q <= cap_cnt_q + 2'h1;
			strap_q   <= {pins_s[1], pins_s[0]};
		end
	end
	assign sensor_id = strap_q;

	// Setup decoding.
	wire       bus_mode   = protocol_setup[pctsc_pkg::SETUP_BUS_MODE];
	wire       var_len    = protocol_setup[pctsc_pkg::SETUP_VARLEN];
	wire       slow_off   = protocol_setup[pctsc_pkg::SETUP_SLOW_OFF];
	wire       interleave = protocol_setup[pctsc_pkg::SETUP_INTERLEAVE];
	wire [2:0] blk_cnt    = protocol_setup[pctsc_pkg::SETUP_BLK_HI:pctsc_pkg::SETUP_BLK_LO];
	wire       blk5_on    = blk_cnt >= pctsc_pkg::BLK5_COUNT;

	// Trigger low-time measurement, ignored while this die owns a frame.
	logic        line_prev_q;
	logic        meas_q;
	logic [15:0] presc_q;
	logic [7:0]  low_ticks_q;
	pctsc_state_t st_q;
	pctsc_state_t st_d;
	wire fall = line_prev_q && !line_s && st_q == S_IDLE;
	wire rise = !line_prev_q && line_s && meas_q;
	wire tick = presc_q == 16'(UT_CYCLES - 1);

	// The base moves with the trigger style; shared tick time keeps all dies aligned.
	wire [7:0] id_base  = var_len ? pctsc_pkg::VAR_BASE_TICKS : pctsc_pkg::CONST_BASE_TICKS;
	wire       id_hit   = id_window(low_ticks_q, id_base, strap_q);
	wire       sync_hit = low_ticks_q >= pctsc_pkg::TRIG_MIN_TICKS;
	wire       trig     = rise && (bus_mode ? id_hit : sync_hit);

	// Count whole unit ticks of the master low pulse, saturating; the fall is seen one cycle into the low time.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			line_prev_q <= 1'b0; // Same as the synchroniser's reset level, so no false edge follows reset.
			meas_q      <= 1'b0;
			presc_q     <= 16'h0000;
			low_ticks_q <= 8'h00;
		end else begin
			line_prev_q <= line_s;
			if (fall) begin
				meas_q      <= 1'b1;
				presc_q     <= 16'h0001;
				low_ticks_q <= 8'h00;
			end else if (rise) begin
				meas_q <= 1'b0;
			end else if (meas_q) begin
				presc_q <= tick ? 16'h0000 : presc_q + 16'h0001;
				if (tick && low_ticks_q != 8'hff) begin
					low_ticks_q <= low_ticks_q + 8'h01;
				end
			end
		end
	end

	// Fast-channel value: fatal beats warning beats clamp beats measurement.
	wire [10:0] flags    = (err_flags & pctsc_pkg::FLAG_VALID) |
	                       (11'((path_underflow | path_overflow)) << pctsc_pkg::FLAG_CLAMP);
	wire        fatal    = |(flags & pctsc_pkg::FATAL_MASK);
	wire        warn     = |(flags & pctsc_pkg::WARN_MASK);
	wire [11:0] fast_val = fatal ? pctsc_pkg::FAST_FATAL :
	                       warn ? pctsc_pkg::FAST_WARN :
	                       path_underflow ? clamp_low :
	                       path_overflow ? clamp_high : meas_value;
	wire [11:0] err_payload = {1'b1, flags};

	// Slow-channel message selection.
	logic [2:0]  slot_q;
	logic [4:0]  sframe_q;
	logic [7:0]  msg_id_q;
	logic [11:0] msg_data_q;
	logic [5:0]  msg_crc_q;
	wire  [2:0]  slot_last = !blk5_on ? 3'h0 : (interleave ? 3'h7 : 3'h4);
	wire         slot_err  = interleave ? !slot_q[0] : slot_q == 3'h0;
	wire  [1:0]  oem_sel   = interleave ? 2'(slot_q >> 1) : 2'(slot_q - 3'h1);
	wire  [7:0]  oem_id    = pctsc_pkg::MSG_ID_OEM5 + 8'(oem_sel);
	logic [11:0] oem_data;

	// OEM payloads are cut contiguously out of the three configuration words.
	always_comb begin
		case (oem_sel)
			2'h0:    oem_data = user_config_word_7[11:0];
			2'h1:    oem_data = {user_config_word_8[7:0], user_config_word_7[15:12]};
			2'h2:    oem_data = {user_config_word_9[3:0], user_config_word_8[15:8]};
			default: oem_data = user_config_word_9[15:4];
		endcase
	end

	wire  [7:0]  next_id   = slot_err ? pctsc_pkg::MSG_ID_ERROR : oem_id;
	wire  [11:0] next_data = slot_err ? err_payload : oem_data;

	// Status bits for the current frame of the current message.
	wire       slow_hi = slow_hi_bit(sframe_q, msg_id_q);
	wire       slow_lo = (sframe_q < 5'h06) ? msg_crc_q[3'(5'h05 - sframe_q)]
	                                        : msg_data_q[4'(5'h11 - sframe_q)];
	wire [3:0] status_nib = slow_off ? 4'h0 : {2'b00, slow_hi, slow_lo};

	// A message is latched at its first frame and advanced one frame per triggered frame.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			slot_q     <= 3'h0;
			sframe_q   <= 5'h00;
			msg_id_q   <= pctsc_pkg::MSG_ID_ERROR;
			msg_data_q <= 12'h000;
			msg_crc_q  <= 6'h00;
		end else if (slow_off) begin
			slot_q   <= 3'h0;
			sframe_q <= 5'h00;
		end else if (st_q == S_STAT && st_d != S_STAT) begin
			sframe_q <= (sframe_q == pctsc_pkg::SLOW_FRAMES - 5'h01) ? 5'h00 : sframe_q + 5'h01;
			if (sframe_q == pctsc_pkg::SLOW_FRAMES - 5'h01) begin
				slot_q <= (slot_q >= slot_last) ? 3'h0 : slot_q + 3'h1;
			end
		end else if (st_q == S_SYNC && sframe_q == 5'h00) begin
			msg_id_q   <= next_id;
			msg_data_q <= next_data;
			msg_crc_q  <= crc6(next_id, next_data);
		end
	end

	// Frame sequencing into the buffer.
	logic [1:0]  dcnt_q;
	logic [11:0] fast_q;
	logic [3:0]  crc_q;
	logic        push;
	logic [5:0]  item;
	logic        buf_ready;
	wire  [3:0]  data_nib = fast_q[4'(4'h8 - {dcnt_q, 2'b00}) +: 4];

	// Each step waits until the buffer has room, so a stalled encoder loses nothing.
	always_comb begin
		st_d = st_q;
		push = 1'b0;
		item = {pctsc_pkg::PCTSC_NIB, 4'h0};
		case (st_q)
			S_IDLE: begin
				if (trig) begin
					st_d = S_SYNC;
				end
			end
			S_SYNC: begin
				push = 1'b1;
				item = {pctsc_pkg::PCTSC_SYNC, 4'h0};
				if (buf_ready) begin
					st_d = S_STAT;
				end
			end
			S_STAT: begin
				push = 1'b1;
				item = {pctsc_pkg::PCTSC_NIB, status_nib};
				if (buf_ready) begin
					st_d = S_DATA;
				end
			end
			S_DATA: begin
				push = 1'b1;
				item = {pctsc_pkg::PCTSC_NIB, data_nib};
				if (buf_ready && dcnt_q == 2'h2) begin
					st_d = S_CRC;
				end
			end
			S_CRC: begin
				push = 1'b1;
				item = {pctsc_pkg::PCTSC_NIB, crc_q};
				if (buf_ready) begin
					st_d = S_END;
				end
			end
			S_END: begin
				push = 1'b1;
				item = {pctsc_pkg::PCTSC_END, 4'h0};
				if (buf_ready) begin
					st_d = S_WAIT;
				end
			end
			S_WAIT: begin
				if (enc_frame_done) begin
					st_d = S_IDLE;
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	// Fresh data is taken while the sync item is queued, after the trigger.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q   <= S_IDLE;
			dcnt_q <= 2'h0;
			fast_q <= 12'h000;
			crc_q  <= 4'h0;
		end else begin
			st_q <= st_d;
			if (st_q == S_SYNC) begin
				fast_q <= fast_val;
				dcnt_q <= 2'h0;
				crc_q  <= pctsc_pkg::CRC4_SEED;
			end else if (st_q == S_DATA && buf_ready) begin
				dcnt_q <= dcnt_q + 2'h1;
				crc_q  <= crc4_step(crc_q, data_nib);
			end
		end
	end

	pctsc_buf2 #(.W(6)) u_buf (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   (item),
		.out_valid (nib_valid),
		.out_ready (nib_ready),
		.out_data  ({nib_kind, nib_data})
	);

	// The pin is only ever pulled low, and only inside this die's own frame.
	assign frame_active = st_q != S_IDLE;
	assign line_out     = 1'b0;
	assign line_oe      = enc_pull_low && frame_active;

	// Self-check words drop reserved bits; a low-byte fault in word B requests reset.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			self_check_status_a <= 16'h0000;
			self_check_status_b <= 16'h0000;
			device_reset_req    <= 1'b0;
		end else begin
			self_check_status_a <= self_check_a_in & pctsc_pkg::STAT_A_MASK;
			self_check_status_b <= self_check_b_in & pctsc_pkg::STAT_B_MASK;
			device_reset_req    <= |(self_check_b_in & pctsc_pkg::STAT_B_RESET);
		end
	end
endmodule : pctsc_core

// file: pctsc_core_chk.sv
// Assertion checker for the trigger and frame core, bound to its ports.
`timescale 1ns/1ps
module pctsc_core_chk (
	// Clock and reset.
	input wire logic        sys_clk,
	input wire logic        rstn,
	// Shared line and encoder side.
	input wire logic        line_in,
	input wire logic        line_out,
	input wire logic        line_oe,
	input wire logic        enc_pull_low,
	input wire logic        enc_frame_done,
	input wire logic        nib_valid,
	input wire logic        nib_ready,
	input wire logic [1:0]  nib_kind,
	input wire logic [3:0]  nib_data,
	// Diagnostics.
	input wire logic [15:0] self_check_a_in,
	input wire logic [15:0] self_check_b_in,
	input wire logic [15:0] self_check_status_a,
	input wire logic [15:0] self_check_status_b,
	input wire logic        device_reset_req,
	input wire logic        frame_active
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Low byte of word B is watched as a signal of its own for $past.
	wire logic [7:0] b_low;
	assign b_low = self_check_b_in[7:0];

	// A die only pulls the line inside its own frame, and only when the encoder asks.
	property p_oe_release; line_oe |-> frame_active && enc_pull_low; endproperty
	a_oe_release: assert property (p_oe_release) else $error("line pulled outside a frame");
	property p_drain; line_out == 1'b0; endproperty
	a_drain: assert property (p_drain) else $error("open drain data not low");
	// The first cycle after reset compares against pre-reset inputs, so it is skipped.
	property p_stat_a; $past(rstn) |-> self_check_status_a == ($past(self_check_a_in) & 16'hfefe); endproperty
	a_stat_a: assert property (p_stat_a) else $error("status word a wrong");
	property p_stat_b; $past(rstn) |-> self_check_status_b == ($past(self_check_b_in) & 16'h5f00); endproperty
	a_stat_b: assert property (p_stat_b) else $error("status word b wrong");
	property p_reset_req; $past(rstn) |-> device_reset_req == (|$past(b_low)); endproperty
	a_reset_req: assert property (p_reset_req) else $error("reset request wrong");
	// A frame opens with a sync pulse item.
	property p_frame_start; $rose(frame_active) |-> ##1 nib_valid && nib_kind == 2'h0; endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame not opened by sync");
	// A frame only follows a master low pulse: the line was low four and five cycles before the frame starts.
	property p_trig; $rose(frame_active) |-> !$past(line_in, 4) && !$past(line_in, 5); endproperty
	a_trig: assert property (p_trig) else $error("frame without trigger");
	property p_nib_hold; nib_valid && !nib_ready |=> nib_valid && $stable(nib_kind) && $stable(nib_data); endproperty
	a_nib_hold: assert property (p_nib_hold) else $error("item lost under stall");
	property p_frame_end; enc_frame_done && frame_active |-> ##[1:2] !frame_active; endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame not closed");
	c_frame: cover property ($rose(frame_active));
	c_stall: cover property (nib_valid && !nib_ready);
	c_reset_req: cover property (device_reset_req);
endmodule : pctsc_core_chk

bind pctsc_core pctsc_core_chk i_chk (.sys_clk(sys_clk), .rstn(rstn), .line_in(line_in), .line_out(line_out),
	.line_oe(line_oe), .enc_pull_low(enc_pull_low), .enc_frame_done(enc_frame_done), .nib_valid(nib_valid),
	.nib_ready(nib_ready), .nib_kind(nib_kind), .nib_data(nib_data), .self_check_a_in(self_check_a_in),
	.self_check_b_in(self_check_b_in), .self_check_status_a(self_check_status_a),
	.self_check_status_b(self_check_status_b), .device_reset_req(device_reset_req), .frame_active(frame_active));

// file: pctsc_ecu_model.sv
// Engine control unit model: bus master that sends trigger pulses on the shared line.
`timescale 1ns/1ps
module pctsc_ecu_model #(
	parameter int UT_CYCLES   = 4,
	parameter int HIGH_CYCLES = 2
) (
	// Clock.
	input wire logic sys_clk,
	// Shared line level and the master's pull-down.
	input wire logic line_lvl,
	output logic     pull_low
);
	initial pull_low = 1'b0;

	// One trigger of whole ticks; all dies share UT_CYCLES, so the low time names the address.
	task automatic trigger(input int ticks);
		int n;
		n = 0;
		// Wait up to 200 cycles for any die to release the line before starting.
		while (line_lvl !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		pull_low = 1'b1;
		repeat (ticks * UT_CYCLES) @(negedge sys_clk);
		pull_low = 1'b0;
		repeat (HIGH_CYCLES) @(negedge sys_clk);
	endtask : trigger
endmodule : pctsc_ecu_model

// file: pctsc_core_test.sv
// Self-checking bench for the trigger and frame core with a master model on the line.
`timescale 1ns/1ps
module pctsc_core_test;
	localparam int UT = 4;
	logic        sys_clk, rstn, strap_a, strap_b, nib_ready, enc_pull_low, enc_frame_done;
	logic        path_underflow, path_overflow, line_oe, line_out, ecu_pull, nib_valid;
	logic        device_reset_req, frame_active;
	logic [15:0] setup, uc7, uc8, uc9, chk_a_in, chk_b_in, stat_a, stat_b;
	logic [11:0] meas;
	logic [10:0] flags;
	logic [1:0]  nib_kind, sensor_id;
	logic [3:0]  nib_data;
	wire logic   line_lvl;
	int          n_fail, checks_done;

	// Open-drain line with pull-up: low while any party pulls.
	assign line_lvl = ~(ecu_pull | line_oe);

	pctsc_core #(.UT_CYCLES(UT)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .line_in(line_lvl), .line_out(line_out),
		.line_oe(line_oe), .strap_id_a(strap_a), .strap_id_b(strap_b), .protocol_setup(setup),
		.user_config_word_7(uc7), .user_config_word_8(uc8), .user_config_word_9(uc9), .clamp_low(12'h011),
		.clamp_high(12'hfee), .meas_value(meas), .err_flags(flags), .path_underflow(path_underflow),
		.path_overflow(path_overflow), .self_check_a_in(chk_a_in), .self_check_b_in(chk_b_in),
		.nib_valid(nib_valid), .nib_ready(nib_ready), .nib_kind(nib_kind), .nib_data(nib_data),
		.enc_pull_low(enc_pull_low), .enc_frame_done(enc_frame_done), .self_check_status_a(stat_a),
		.self_check_status_b(stat_b), .device_reset_req(device_reset_req), .frame_active(frame_active),
		.sensor_id(sensor_id));
	pctsc_ecu_model #(.UT_CYCLES(UT)) i_ecu (.sys_clk(sys_clk), .line_lvl(line_lvl), .pull_low(ecu_pull));

	// Free-running 40 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic finish_test;
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task automatic do_reset(input logic a, input logic b);
		@(negedge sys_clk);
		rstn = 1'b0;
		strap_a = a;
		strap_b = b;
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (6) @(negedge sys_clk);
		check({14'h0000, sensor_id}, {14'h0000, b, a});
	endtask : do_reset

	// One trigger, then act as nibble encoder with stalls on every other cycle.
	task automatic run_frame(input int ticks, input logic go, input logic [11:0] exp_fast, output logic [3:0] st);
		logic [3:0] got [7];
		int         n, k;
		n = 0;
		st = 4'h0;
		check({15'h0000, line_lvl}, 16'h0001);
		i_ecu.trigger(ticks);
		for (k = 0; k < 60 && n < 7; k++) begin
			@(negedge sys_clk);
			if (enc_pull_low === 1'b1) check({15'h0000, line_lvl}, 16'h0000);
			enc_pull_low = (n == 1);
			nib_ready = k[0];
			if (nib_valid === 1'b1 && nib_ready === 1'b1) begin
				check({14'h0000, nib_kind}, (n == 0) ? 16'h0000 : (n == 6) ? 16'h0002 : 16'h0001);
				got[n] = nib_data;
				n++;
			end
		end
		// Keep ready through the edge that takes the last item.
		@(negedge sys_clk);
		nib_ready = 1'b0;
		enc_pull_low = 1'b0;
		enc_frame_done = go;
		@(negedge sys_clk);
		enc_frame_done = 1'b0;
		for (k = 0; k < 4 && frame_active !== 1'b0; k++) @(negedge sys_clk);
		if (frame_active !== 1'b0 || (go === 1'b1 && n < 7)) begin
			n_fail++;
			finish_test();
		end
		if (go !== 1'b1) begin
			check(n[15:0], 16'h0000);
			return;
		end
		check({4'h0, got[2], got[3], got[4]}, {4'h0, exp_fast});
		check({12'h000, got[5]}, {12'h000, crc4_ref(exp_fast)});
		check({12'h000, got[1] & 4'hc}, 16'h0000);
		st = got[1];
	endtask : run_frame

	// Reference CRC-4 over the three data nibbles, most significant bit first.
	function automatic logic [3:0] crc4_ref(input logic [11:0] v);
		logic [3:0] c;
		c = 4'h5;
		for (int i = 11; i >= 0; i--) begin
			c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'hd : 4'h0);
		end
		return c;
	endfunction : crc4_ref

	function automatic logic [11:0] exp_fast(input int i);
		case (i)
			0, 1, 2, 4, 9: return 12'hffa;
			3, 6, 7, 10: return 12'hffb;
			11: return 12'h011;
			12: return 12'hfee;
			default: return meas;
		endcase
	endfunction : exp_fast

	task automatic t_status;
		chk_a_in = 16'hffff;
		chk_b_in = 16'hffff;
		repeat (2) @(negedge sys_clk);
		check(stat_a, 16'hfefe);
		check(stat_b, 16'h5f00);
		check({15'h0000, device_reset_req}, 16'h0001);
		chk_a_in = 16'h0101;
		chk_b_in = 16'h5f00;
		repeat (2) @(negedge sys_clk);
		check(stat_a, 16'h0000);
		check({15'h0000, device_reset_req}, 16'h0000);
	endtask : t_status

	// Each flag alone, then underflow and overflow, with the slow channel off.
	task automatic t_errmap;
		logic [3:0] s;
		int         i;
		setup = 16'h0010;
		for (i = 0; i < 13; i++) begin
			flags = (i < 11) ? (11'h001 << i) : 11'h000;
			path_underflow = (i == 11);
			path_overflow = (i == 12);
			run_frame(2, 1'b1, exp_fast(i), s);
			check({12'h000, s}, 16'h0000);
		end
		flags = 11'h000;
		path_underflow = 1'b0;
		path_overflow = 1'b0;
	endtask : t_errmap

	// Each nonzero ID, both trigger styles, wrong and right address.
	task automatic t_bus;
		logic [3:0] s;
		int         i;
		do_reset(1'b0, 1'b0);
		for (i = 1; i < 4; i++) begin
			do_reset(i[0], i[1]);
			setup = 16'h0410;
			run_frame(6 + 3 * i, 1'b0, meas, s);
			run_frame(3 + 3 * i, 1'b1, meas, s);
			setup = 16'h0610;
			run_frame(3 + 3 * i, 1'b0, meas, s);
			run_frame(6 + 3 * i, 1'b1, meas, s);
		end
	endtask : t_bus

	task automatic get_msg(output logic [7:0] id, output logic [11:0] data);
		logic [3:0] s;
		int         f;
		for (f = 0; f < 18; f++) begin
			run_frame(2, 1'b1, 12'hffb, s);
			if (f < 6) check({15'h0000, s[1]}, 16'h0001);
			if (f == 6 || f == 7 || f == 12 || f == 17) check({15'h0000, s[1]}, 16'h0000);
			if (f >= 8 && f <= 11) id[15 - f] = s[1];
			if (f >= 13 && f <= 16) id[16 - f] = s[1];
			if (f >= 6) data[17 - f] = s[0];
		end
	endtask : get_msg

	// Block five messages after reset, plain or with the error message interleaved.
	task automatic t_slow(input logic il);
		logic [7:0]  id;
		logic [11:0] d, ed;
		int          m, o;
		do_reset(1'b1, 1'b0);
		setup = {15'h0004, il};
		flags = 11'h008;
		for (m = 0; m < 5 - il; m++) begin
			o = il ? (m % 2 == 1 ? m / 2 + 1 : 0) : m;
			ed = (o == 0) ? 12'h808 : (o == 1) ? uc7[11:0] : (o == 2) ? {uc8[7:0], uc7[15:12]} :
				(o == 3) ? {uc9[3:0], uc8[15:8]} : uc9[15:4];
			get_msg(id, d);
			check({8'h00, id}, (o == 0) ? 16'h0001 : 16'h0093 + o[15:0]);
			check({4'h0, d}, {4'h0, ed});
		end
		flags = 11'h000;
	endtask : t_slow

	// Main sequence.
	initial begin
		n_fail = 0;
		checks_done = 0;
		rstn = 1'b0;
		{strap_a, strap_b, nib_ready, enc_pull_low, enc_frame_done, path_underflow, path_overflow} = 7'h00;
		setup = 16'h0010;
		{uc7, uc8, uc9} = {16'hc3a5, 16'h5e71, 16'h9b2d};
		{chk_a_in, chk_b_in} = 32'h0000_0000;
		meas = 12'h5a3;
		flags = 11'h000;
		do_reset(1'b1, 1'b0);
		t_status;
		t_errmap;
		t_bus;
		t_slow(1'b0);
		t_slow(1'b1);
		finish_test();
	end
endmodule : pctsc_core_test
